// ==== logic/dphr_pkg.sv ====
// Package: register map, field layout and widths of the protected high region
package dphr_pkg;
  localparam int DPHR_ADDR_W = 8;
  localparam int DPHR_HAW = 48;
  localparam int DPHR_N = 11;
  localparam int DPHR_FLD_LO = DPHR_N + 1;
  localparam logic [7:0] DPHR_OFF_BASE_LO = 8'h70;
  localparam logic [7:0] DPHR_OFF_BASE_HI = 8'h74;
  localparam logic [7:0] DPHR_OFF_LIMIT_LO = 8'h78;
  localparam logic [7:0] DPHR_OFF_LIMIT_HI = 8'h7C;
  localparam logic [7:0] DPHR_OFF_CTRL = 8'h60;
  localparam logic [7:0] DPHR_OFF_STATUS = 8'h64;
  localparam int DPHR_CTRL_EN_BIT = 0;
  localparam int DPHR_CTRL_SUP_BIT = 1;
  localparam int DPHR_STAT_ACT_BIT = 0;
  localparam int DPHR_STAT_VALID_BIT = 1;
  localparam logic [63:0] DPHR_BASE_RST = 64'h0000000000000000;
  localparam logic [63:0] DPHR_LIMIT_RST = 64'h0000000000000000;
  localparam logic [1:0] DPHR_RESP_OKAY = 2'h0;
  localparam logic [1:0] DPHR_RESP_SLVERR = 2'h2;
  // Mask of the implemented field bits HOST_ADDRESS_WIDTH-1 down to N+1
  localparam logic [63:0] DPHR_FLD_MASK =
    ((64'h1 << DPHR_HAW) - 64'h1) & ~((64'h1 << DPHR_FLD_LO) - 64'h1);
endpackage : dphr_pkg

// ==== logic/dphr_range_check.sv ====
// Region decode: inclusive range check of one DMA address
module dphr_range_check
  import dphr_pkg::*;
(
  input wire logic [63:0] base_in,
  input wire logic [63:0] limit_in,
  input wire logic [63:0] addr_in,
  output logic valid_out,
  output logic hit_out
);
  logic [DPHR_HAW-1:0] dec_base;
  logic [DPHR_HAW-1:0] dec_limit;
  logic [DPHR_HAW-1:0] addr_cut;
  logic [DPHR_N:0] ones;

  always_comb begin
    ones = '1;
    // Low bits decode as zeros in the base, ones in the limit
    dec_base = {base_in[DPHR_HAW-1:DPHR_FLD_LO],
      {(DPHR_FLD_LO){1'b0}}}; // see RULE_04
    dec_limit = {limit_in[DPHR_HAW-1:DPHR_FLD_LO], ones}; // see RULE_05
    addr_cut = addr_in[DPHR_HAW-1:0]; // see RULE_10
    valid_out = (dec_limit >= dec_base); // see RULE_09
    hit_out = valid_out && (addr_cut >= dec_base) // see RULE_08
      && (addr_cut <= dec_limit); // see RULE_11
  end
endmodule : dphr_range_check

// ==== logic/dphr_top.sv ====
// Top: AXI4-Lite register file and DMA blocking of the protected high region
// Notes on behaviour
// RULE_01 - Software programs base and limit before turning protection on.
// RULE_02 - Software never writes base or limit while protection is active.
// RULE_03 - Without the support flag both registers are read-only.
// RULE_04 - Base low bits decode as zeros; base aligned to 2^(N+1).
// RULE_05 - Limit low bits decode as ones; limit ends an aligned block.
// RULE_06 - Reserved low bits read zero; software sizes N by writing ones.
// RULE_07 - Bits at and above the host address width are not stored.
// RULE_08 - Equal upper bits protect exactly one aligned 2^(N+1) block.
// RULE_09 - Limit below base disables the region.
// RULE_10 - Base and limit may lie above or below 4GB.
// RULE_11 - Limit is the last included address; range is inclusive.
// RULE_12 - Fields sit at bits 63 down to N+1; lower bits reserved.
// RULE_13 - When enabled and valid, addresses inside the range are blocked; the code also requires the support flag.
module dphr_top
  import dphr_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic high_region_supported_flag_in,
  input wire logic [63:0] dma_addr_in,
  input wire logic dma_valid_in,
  output logic dma_block_out,
  output logic protection_active_flag_out,
  input wire logic [DPHR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DPHR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic [63:0] base;
    logic [63:0] limit;
    logic enable;
    logic aw_held;
    logic [DPHR_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic block;
    logic [2:0] sup_sync;
    logic sup;
  } dphr_state_t;

  dphr_state_t state_r;
  dphr_state_t state_nxt;
  logic region_valid;
  logic region_hit;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte-lane merge of one 32-bit half
  function automatic logic [31:0] dphr_merge_f(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : dphr_merge_f

  // Address decode used by the write path for the write response
  function automatic logic dphr_mapped_f(input logic [DPHR_ADDR_W-1:0] a);
    return (a == DPHR_OFF_BASE_LO) || (a == DPHR_OFF_BASE_HI) ||
      (a == DPHR_OFF_LIMIT_LO) || (a == DPHR_OFF_LIMIT_HI) ||
      (a == DPHR_OFF_CTRL) || (a == DPHR_OFF_STATUS);
  endfunction : dphr_mapped_f

  // ---------------------------------------------------------------
  // Region decode
  // ---------------------------------------------------------------
  dphr_range_check u_range (
    .base_in(state_r.base),
    .limit_in(state_r.limit),
    .addr_in(dma_addr_in),
    .valid_out(region_valid),
    .hit_out(region_hit)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic wr_go;
    logic wr_lock;
    logic [DPHR_ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [63:0] wide;
    wr_go = 1'b0;
    wr_lock = 1'b0;
    wa = '0;
    wd = '0;
    ws = '0;
    wide = '0;
    state_nxt = state_r;
    state_nxt.sup_sync = {state_r.sup_sync[1:0],
      high_region_supported_flag_in};
    if (state_r.sup_sync[2] == state_r.sup_sync[1]) begin
      state_nxt.sup = state_r.sup_sync[1];
    end
    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_nxt.w_held = 1'b1;
      state_nxt.w_data = s_axi_wdata;
      state_nxt.w_strb = s_axi_wstrb;
    end
    if (state_r.aw_held && state_r.w_held && !state_r.bvalid) begin
      wr_go = 1'b1;
      wa = state_r.aw_addr;
      wd = state_r.w_data;
      ws = state_r.w_strb;
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = dphr_mapped_f(wa) ? DPHR_RESP_OKAY
        : DPHR_RESP_SLVERR;
    end
    if (state_r.bvalid && s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end
    // Unsupported region locks both registers as read-only
    wr_lock = !state_r.sup; // see RULE_03
    if (wr_go) begin
      case (wa)
        DPHR_OFF_BASE_LO: begin
          if (!wr_lock) begin
            wide = {state_r.base[63:32],
              dphr_merge_f(state_r.base[31:0], wd, ws)};
            state_nxt.base = wide & DPHR_FLD_MASK; // see RULE_04
          end
        end
        DPHR_OFF_BASE_HI: begin
          if (!wr_lock) begin
            wide = {dphr_merge_f(state_r.base[63:32], wd, ws),
              state_r.base[31:0]};
            state_nxt.base = wide & DPHR_FLD_MASK; // see RULE_07
          end
        end
        DPHR_OFF_LIMIT_LO: begin
          if (!wr_lock) begin
            wide = {state_r.limit[63:32],
              dphr_merge_f(state_r.limit[31:0], wd, ws)};
            state_nxt.limit = wide & DPHR_FLD_MASK; // see RULE_06
          end
        end
        DPHR_OFF_LIMIT_HI: begin
          if (!wr_lock) begin
            wide = {dphr_merge_f(state_r.limit[63:32], wd, ws),
              state_r.limit[31:0]};
            state_nxt.limit = wide & DPHR_FLD_MASK; // see RULE_12
          end
        end
        DPHR_OFF_CTRL: begin
          if (ws[0]) begin
            state_nxt.enable = wd[DPHR_CTRL_EN_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp = DPHR_RESP_OKAY;
      case (s_axi_araddr)
        DPHR_OFF_BASE_LO: state_nxt.rdata = state_r.base[31:0];
        DPHR_OFF_BASE_HI: state_nxt.rdata = state_r.base[63:32];
        DPHR_OFF_LIMIT_LO: state_nxt.rdata = state_r.limit[31:0];
        DPHR_OFF_LIMIT_HI: state_nxt.rdata = state_r.limit[63:32];
        DPHR_OFF_CTRL: begin
          state_nxt.rdata = '0;
          state_nxt.rdata[DPHR_CTRL_EN_BIT] = state_r.enable;
          state_nxt.rdata[DPHR_CTRL_SUP_BIT] = state_r.sup;
        end
        DPHR_OFF_STATUS: begin
          state_nxt.rdata = '0;
          state_nxt.rdata[DPHR_STAT_ACT_BIT] = state_r.enable;
          state_nxt.rdata[DPHR_STAT_VALID_BIT] = region_valid;
        end
        default: begin
          state_nxt.rdata = '0;
          state_nxt.rresp = DPHR_RESP_SLVERR;
        end
      endcase
    end else if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end
    // DMA blocking, registered; decode is valid above or below 4GB
    state_nxt.block = dma_valid_in && state_r.enable && state_r.sup &&
      region_hit; // see RULE_13
    if (srst_in) begin
      state_nxt = '0;
      state_nxt.base = DPHR_BASE_RST;
      state_nxt.limit = DPHR_LIMIT_RST;
    end
  end

  always_ff @(posedge clk_in) begin
    state_r <= state_nxt;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !state_r.aw_held && !srst_in;
  assign s_axi_wready = !state_r.w_held && !srst_in;
  assign s_axi_bvalid = state_r.bvalid;
  assign s_axi_bresp = state_r.bresp;
  assign s_axi_arready = !state_r.rvalid && !srst_in;
  assign s_axi_rvalid = state_r.rvalid;
  assign s_axi_rdata = state_r.rdata;
  assign s_axi_rresp = state_r.rresp;
  assign dma_block_out = state_r.block;
  assign protection_active_flag_out = state_r.enable;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_ro_when_unsup;
    @(posedge clk_in) disable iff (srst_in)
    !state_r.sup |=> $stable(state_r.base) && $stable(state_r.limit);
  endproperty
  a_ro_when_unsup: assert property (p_ro_when_unsup) // see RULE_03
    else $error("region register changed while unsupported");

  property p_base_low_zero;
    @(posedge clk_in) disable iff (srst_in)
    state_r.base[DPHR_N:0] == '0;
  endproperty
  a_base_low_zero: assert property (p_base_low_zero) // see RULE_06
    else $error("base reserved bits not zero");

  property p_limit_low_zero;
    @(posedge clk_in) disable iff (srst_in)
    state_r.limit[DPHR_N:0] == '0 && state_r.limit[63:DPHR_HAW] == '0;
  endproperty
  a_limit_low_zero: assert property (p_limit_low_zero) // see RULE_07
    else $error("limit reserved or high bits not zero");

  property p_disabled_region;
    @(posedge clk_in) disable iff (srst_in)
    (state_r.limit[DPHR_HAW-1:DPHR_FLD_LO] <
      state_r.base[DPHR_HAW-1:DPHR_FLD_LO]) |=> !dma_block_out;
  endproperty
  a_disabled_region: assert property (p_disabled_region) // see RULE_09
    else $error("block raised with limit below base");

  property p_block_needs_enable;
    @(posedge clk_in) disable iff (srst_in)
    dma_block_out |-> $past(state_r.enable) && $past(dma_valid_in);
  endproperty
  a_block_needs_enable: assert property (p_block_needs_enable) // see RULE_13
    else $error("block without enable or request");

  property p_block_at_base;
    @(posedge clk_in) disable iff (srst_in)
    (dma_valid_in && state_r.enable && state_r.sup && region_valid &&
      dma_addr_in[DPHR_HAW-1:0] == state_r.base[DPHR_HAW-1:0])
      |=> dma_block_out;
  endproperty
  a_block_at_base: assert property (p_block_at_base) // see RULE_04
    else $error("base address not blocked");

  property p_block_at_limit;
    @(posedge clk_in) disable iff (srst_in)
    (dma_valid_in && state_r.enable && state_r.sup && region_valid &&
      dma_addr_in[DPHR_HAW-1:0] == (state_r.limit[DPHR_HAW-1:0] |
      DPHR_HAW'((64'h1 << DPHR_FLD_LO) - 64'h1))) |=> dma_block_out;
  endproperty
  a_block_at_limit: assert property (p_block_at_limit) // see RULE_11
    else $error("last limit byte not blocked");

  property p_write_resp;
    @(posedge clk_in) disable iff (srst_in)
    (state_r.aw_held && state_r.w_held && !state_r.bvalid) |=> s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) // see RULE_12
    else $error("write response missing");
endmodule : dphr_top

// ==== dv/dphr_top_bench.sv ====
// Testbench of the protected high region block
module dphr_top_bench
  import dphr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic sup_flag = 1'b0;
  logic [63:0] dma_addr_in = 64'h0;
  logic dma_valid_in = 1'b0;
  logic dma_block_out, prot_out;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;

  always #5 clk_in = ~clk_in;

  dphr_top u_dphr_top (
    .clk_in(clk_in), .srst_in(srst_in),
    .high_region_supported_flag_in(sup_flag),
    .dma_addr_in(dma_addr_in), .dma_valid_in(dma_valid_in),
    .dma_block_out(dma_block_out),
    .protection_active_flag_out(prot_out),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Ready and valid are sampled mid-cycle; inputs move only after edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok, aw_done, w_done, got;
    aw_done = 1'b0;
    w_done = 1'b0;
    got = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clk_in);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      @(posedge clk_in);
      if (aw_ok) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_ok) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!got) begin
      @(negedge clk_in);
      got = bvalid;
      if (got) chk("bresp", {62'h0, er}, {62'h0, bresp});
      @(posedge clk_in);
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ok, got;
    ok = 1'b0;
    got = 1'b0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok) begin
      @(negedge clk_in);
      ok = arready;
      @(posedge clk_in);
    end
    arvalid <= 1'b0;
    while (!got) begin
      @(negedge clk_in);
      got = rvalid;
      if (got) begin
        chk("rdata", {32'h0, e}, {32'h0, rdata});
        chk("rresp", {62'h0, er}, {62'h0, rresp});
      end
      @(posedge clk_in);
    end
    rready <= 1'b0;
  endtask : rd

  task automatic dma(input logic [63:0] a, input logic e);
    @(posedge clk_in);
    dma_addr_in <= a;
    dma_valid_in <= 1'b1;
    @(posedge clk_in);
    dma_valid_in <= 1'b0;
    @(negedge clk_in);
    chk("dma_block", {63'h0, e}, {63'h0, dma_block_out});
  endtask : dma

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(8'h70, 32'h0, DPHR_RESP_OKAY);
    rd(8'h74, 32'h0, DPHR_RESP_OKAY);
    rd(8'h78, 32'h0, DPHR_RESP_OKAY);
    rd(8'h7C, 32'h0, DPHR_RESP_OKAY);
    $display("test reset done");
  endtask : t_reset

  task automatic t_readonly();
    wr(8'h70, 32'hFFFFFFFF, DPHR_RESP_OKAY);
    wr(8'h7C, 32'hFFFFFFFF, DPHR_RESP_OKAY);
    rd(8'h70, 32'h0, DPHR_RESP_OKAY);
    rd(8'h7C, 32'h0, DPHR_RESP_OKAY);
    $display("test readonly done");
  endtask : t_readonly

  task automatic t_sizing();
    wr(8'h70, 32'hFFFFFFFF, DPHR_RESP_OKAY);
    wr(8'h74, 32'hFFFFFFFF, DPHR_RESP_OKAY);
    wr(8'h78, 32'hFFFFFFFF, DPHR_RESP_OKAY);
    wr(8'h7C, 32'hFFFFFFFF, DPHR_RESP_OKAY);
    rd(8'h70, 32'hFFFFF000, DPHR_RESP_OKAY);
    rd(8'h74, 32'h0000FFFF, DPHR_RESP_OKAY);
    rd(8'h78, 32'hFFFFF000, DPHR_RESP_OKAY);
    rd(8'h7C, 32'h0000FFFF, DPHR_RESP_OKAY);
    // Single byte lane clears only base bits 39:32
    wstrb <= 4'h1;
    wr(8'h74, 32'h00000000, DPHR_RESP_OKAY);
    wstrb <= 4'hF;
    rd(8'h74, 32'h0000FF00, DPHR_RESP_OKAY);
    $display("test sizing done");
  endtask : t_sizing

  task automatic t_block();
    logic [63:0] b;
    b = 64'h0000000123456000;
    wr(8'h70, 32'h23456ABC, DPHR_RESP_OKAY);
    wr(8'h74, 32'h00000001, DPHR_RESP_OKAY);
    wr(8'h78, 32'h23456000, DPHR_RESP_OKAY);
    wr(8'h7C, 32'h00000001, DPHR_RESP_OKAY);
    rd(8'h70, 32'h23456000, DPHR_RESP_OKAY);
    dma(b, 1'b0);
    wr(DPHR_OFF_CTRL, 32'h1, DPHR_RESP_OKAY);
    @(negedge clk_in);
    chk("prot_flag", 64'h1, {63'h0, prot_out});
    rd(DPHR_OFF_STATUS, 32'h3, DPHR_RESP_OKAY);
    dma(b - 64'h1, 1'b0);
    dma(b, 1'b1);
    dma(b + 64'hFFF, 1'b1);
    dma(b + 64'h1000, 1'b0);
    dma(b | 64'h0001000000000000, 1'b1);
    wr(DPHR_OFF_CTRL, 32'h0, DPHR_RESP_OKAY);
    @(negedge clk_in);
    chk("prot_flag", 64'h0, {63'h0, prot_out});
    dma(b, 1'b0);
    $display("test block done");
  endtask : t_block

  task automatic t_inverted();
    wr(8'h70, 32'h00002000, DPHR_RESP_OKAY);
    wr(8'h74, 32'h0, DPHR_RESP_OKAY);
    wr(8'h78, 32'h00001000, DPHR_RESP_OKAY);
    wr(8'h7C, 32'h0, DPHR_RESP_OKAY);
    wr(DPHR_OFF_CTRL, 32'h1, DPHR_RESP_OKAY);
    rd(DPHR_OFF_STATUS, 32'h1, DPHR_RESP_OKAY);
    dma(64'h1800, 1'b0);
    dma(64'h2000, 1'b0);
    wr(DPHR_OFF_CTRL, 32'h0, DPHR_RESP_OKAY);
    $display("test inverted done");
  endtask : t_inverted

  task automatic t_unmapped();
    rd(8'h20, 32'h0, DPHR_RESP_SLVERR);
    wr(8'h24, 32'h12345678, DPHR_RESP_SLVERR);
    $display("test unmapped done");
  endtask : t_unmapped

  // ----------------------------------------------------------------
  // Sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_readonly();
    @(posedge clk_in);
    sup_flag <= 1'b1;
    repeat (8) @(posedge clk_in);
    t_sizing();
    t_block();
    t_inverted();
    t_unmapped();
    final_report();
  end
endmodule : dphr_top_bench
